// *** common/sipp_pkg.sv ***
// Shared constants and types for the synthesiser serial programming port.
package sipp_pkg;

  // Address byte layout, most significant bit first.
  localparam logic [4:0] SIPP_ADDR_FIXED  = 5'h18;
  localparam logic [1:0] SIPP_SEL_ALWAYS  = 2'h1;
  localparam logic [1:0] SIPP_SEL_LOW     = 2'h0;
  localparam logic [1:0] SIPP_SEL_MID     = 2'h2;
  localparam logic [1:0] SIPP_SEL_HIGH    = 2'h3;

  // Control byte field positions.
  localparam int SIPP_CTL_LEAD  = 7;
  localparam int SIPP_CTL_PUMP  = 6;
  localparam int SIPP_CTL_TEST  = 5;
  localparam int SIPP_CTL_OFF   = 4;
  localparam int SIPP_CTL_DRIVE = 0;

  // Port control byte field positions.
  localparam int SIPP_PRT_7 = 7;
  localparam int SIPP_PRT_6 = 6;
  localparam int SIPP_PRT_5 = 5;
  localparam int SIPP_PRT_4 = 4;
  localparam int SIPP_PRT_3 = 3;
  localparam int SIPP_PRT_0 = 0;

  // Reset values: every port off, pump running, drive enabled.
  localparam logic [7:0]  SIPP_CTL_RESET   = 8'h8E;
  localparam logic [7:0]  SIPP_PRT_RESET   = 8'h00;
  localparam logic [7:0]  SIPP_UPPER_RESET = 8'h00;
  localparam logic [14:0] SIPP_RATIO_RESET = 15'h0000;

  // Converter codes from the lowest band upward.
  localparam logic [2:0] SIPP_CONV_B0 = 3'h0;
  localparam logic [2:0] SIPP_CONV_B1 = 3'h1;
  localparam logic [2:0] SIPP_CONV_B2 = 3'h2;
  localparam logic [2:0] SIPP_CONV_B3 = 3'h3;
  localparam logic [2:0] SIPP_CONV_B4 = 3'h4;

  localparam logic [3:0] SIPP_BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    SIPP_IDLE = 3'h0,
    SIPP_ADDR = 3'h1,
    SIPP_ACK  = 3'h3,
    SIPP_WR   = 3'h2,
    SIPP_RD   = 3'h6,
    SIPP_RACK = 3'h7,
    SIPP_WAIT = 3'h5
  } sipp_state_t;

  typedef enum logic [1:0] {
    SIPP_NEXT_SEL   = 2'h0,
    SIPP_NEXT_LOWER = 2'h1,
    SIPP_NEXT_PORTS = 2'h3
  } sipp_next_t;

endpackage : sipp_pkg

// *** hw/sipp_band.sv ***
// Comparator band decode for the converter code and the alternate address.
module sipp_band
  import sipp_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Synchronised comparator outputs
  input  wire logic [3:0] conv_cmp,
  input  wire logic [3:0] sel_cmp,
  // Decoded results
  output logic      [2:0] conv_code,
  output logic      [1:0] alt_sel,
  output logic            alt_valid
);

  function automatic logic [2:0] therm_count(input logic [3:0] t);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (t[i]) begin
        c = 3'(i + 1);
      end
    end
    return c;
  endfunction : therm_count

  always_ff @(posedge clk) begin
    if (reset) begin
      conv_code <= SIPP_CONV_B0;
    end else begin
      case (therm_count(conv_cmp))
        3'h1:    conv_code <= SIPP_CONV_B1;
        3'h2:    conv_code <= SIPP_CONV_B2;
        3'h3:    conv_code <= SIPP_CONV_B3;
        3'h4:    conv_code <= SIPP_CONV_B4;
        default: conv_code <= SIPP_CONV_B0;
      endcase
    end
  end

  // band to address select; gaps between bands select nothing extra.
  always_ff @(posedge clk) begin
    if (reset) begin
      alt_sel   <= SIPP_SEL_LOW;
      alt_valid <= 1'b0;
    end else begin
      case (therm_count(sel_cmp))
        3'h0:    {alt_sel, alt_valid} <= {SIPP_SEL_LOW, 1'b1};
        3'h2:    {alt_sel, alt_valid} <= {SIPP_SEL_MID, 1'b1};
        3'h4:    {alt_sel, alt_valid} <= {SIPP_SEL_HIGH, 1'b1};
        default: {alt_sel, alt_valid} <= {SIPP_SEL_LOW, 1'b0};
      endcase
    end
  end

  a_conv_top:
    assert property (@(posedge clk) disable iff (reset) conv_cmp == 4'hF |=> conv_code == SIPP_CONV_B4)
    else $error("converter top band not coded 100");

endmodule : sipp_band

// *** hw/sipp_sync.sv ***
// Two-stage synchroniser for a vector of asynchronous pin levels.
module sipp_sync
  import sipp_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // Only the second stage is ever read by other logic.
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : sipp_sync

// *** hw/sipp_top.sv ***
// Two-wire programming and status port of a tuner frequency synthesiser.
module sipp_top
  import sipp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Serial bus pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Analog front end
  input  wire logic        supply_low,
  input  wire logic        lock_flag,
  input  wire logic [3:0]  conv_cmp,
  input  wire logic [3:0]  sel_cmp,
  // Port pins
  input  wire logic        io_port_4_i,
  input  wire logic        io_port_5_i,
  input  wire logic        io_port_7_i,
  output logic             out_port_0,
  output logic             out_port_3,
  output logic             io_port_4_oe,
  output logic             io_port_5_oe,
  output logic             io_port_6_oe,
  output logic             io_port_7_oe,
  output logic             io_port_o,
  // Synthesiser controls
  output logic [14:0]      divider_ratio,
  output logic             pump_current_sel,
  output logic             test_mode_sel,
  output logic             pump_off,
  output logic             varactor_drive_off
);

  ////////////////////////////////////////////////////////////////////////////

  logic [6:0]  sync_q;
  logic [3:0]  conv_cmp_s;
  logic [3:0]  sel_cmp_s;
  logic        scl_s;
  logic        sda_s;
  logic        scl_n_s;
  logic        sda_n_s;
  logic        lock_s;
  logic        low_s;
  logic        port7_level;
  logic        port5_level;
  logic        port4_level;
  logic [2:0]  conv_code;
  logic [1:0]  alt_sel;
  logic        alt_valid;

  // Bus lines enter inverted, so a cleared synchroniser reads as an idle high bus and no false edge follows reset.
  sipp_sync #(.W(15)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({~scl_i, ~sda_i, lock_flag, supply_low, io_port_7_i, io_port_5_i, io_port_4_i, conv_cmp, sel_cmp}),
    .q     ({sync_q, conv_cmp_s, sel_cmp_s})
  );

  assign {scl_n_s, sda_n_s, lock_s, low_s, port7_level, port5_level, port4_level} = sync_q;
  assign scl_s = ~scl_n_s;
  assign sda_s = ~sda_n_s;

  sipp_band u_band (
    .clk       (clk),
    .reset     (reset),
    .conv_cmp  (conv_cmp_s),
    .sel_cmp   (sel_cmp_s),
    .conv_code (conv_code),
    .alt_sel   (alt_sel),
    .alt_valid (alt_valid)
  );

  ////////////////////////////////////////////////////////////////////////////

  logic scl_q;
  logic sda_q;
  logic bus_start;
  logic bus_stop;
  logic scl_rise;
  logic scl_fall;

  always_ff @(posedge clk) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
  assign bus_stop  = scl_s & scl_q & ~sda_q & sda_s;
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;

  ////////////////////////////////////////////////////////////////////////////

  sipp_state_t state_reg;
  logic [7:0]  shift_reg;
  logic [3:0]  cnt_reg;
  logic        rw_reg;
  logic        mack_reg;
  logic        sda_oe_reg;
  logic        por_reg;
  logic [7:0]  status;
  logic        byte_done;
  logic        addr_hit;
  logic        wr_commit;

  // fixed prefix and select bits must match.
  function automatic logic addr_match(input logic [7:0] b, input logic [1:0] alt, input logic ok);
    // fixed select always, band select when valid.
    return (b[7:3] == SIPP_ADDR_FIXED) && (b[2:1] == SIPP_SEL_ALWAYS || (ok && b[2:1] == alt));
  endfunction : addr_match

  // status layout with lock, port levels and converter code.
  // port seven, five and four levels.
  assign status    = {por_reg, lock_s, port7_level, port5_level, port4_level, conv_code};
  assign byte_done = scl_fall && cnt_reg == SIPP_BITS_PER_BYTE;
  assign addr_hit  = state_reg == SIPP_ADDR && byte_done && addr_match(shift_reg, alt_sel, alt_valid);
  assign wr_commit = state_reg == SIPP_WR && byte_done;

  // Start and stop are honoured in any state so a stalled master can recover.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg  <= SIPP_IDLE;
      shift_reg  <= 8'h00;
      cnt_reg    <= 4'h0;
      rw_reg     <= 1'b0;
      mack_reg   <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (bus_start) begin
      state_reg  <= SIPP_ADDR;
      cnt_reg    <= 4'h0;
      rw_reg     <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (bus_stop) begin
      state_reg  <= SIPP_IDLE;
      rw_reg     <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        SIPP_ADDR, SIPP_WR: begin
          if (scl_rise && cnt_reg < SIPP_BITS_PER_BYTE) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            cnt_reg   <= cnt_reg + 4'h1;
          end
          // acknowledge matching address and every written byte.
          if (addr_hit || wr_commit) begin
            state_reg  <= SIPP_ACK;
            sda_oe_reg <= 1'b1;
            if (addr_hit) begin
              rw_reg <= shift_reg[0];
            end
          end else if (byte_done) begin
            state_reg <= SIPP_WAIT;
          end
        end
        SIPP_ACK: begin
          if (scl_fall) begin
            cnt_reg <= 4'h0;
            // status goes out most significant bit first.
            if (rw_reg) begin
              state_reg  <= SIPP_RD;
              shift_reg  <= status;
              sda_oe_reg <= ~status[7];
            end else begin
              state_reg  <= SIPP_WR;
              sda_oe_reg <= 1'b0;
            end
          end
        end
        SIPP_RD: begin
          if (scl_fall) begin
            if (cnt_reg == 4'h7) begin
              state_reg  <= SIPP_RACK;
              sda_oe_reg <= 1'b0;
            end else begin
              shift_reg  <= {shift_reg[6:0], 1'b0};
              sda_oe_reg <= ~shift_reg[6];
              cnt_reg    <= cnt_reg + 4'h1;
            end
          end
        end
        SIPP_RACK: begin
          if (scl_rise) begin
            mack_reg <= ~sda_s;
          end
          // a master acknowledge asks for another status byte.
          if (scl_fall) begin
            cnt_reg <= 4'h0;
            if (mack_reg) begin
              state_reg  <= SIPP_RD;
              shift_reg  <= status;
              sda_oe_reg <= ~status[7];
            end else begin
              state_reg <= SIPP_WAIT;
            end
          end
        end
        SIPP_IDLE, SIPP_WAIT: begin
          sda_oe_reg <= 1'b0;
        end
        default: begin
          state_reg  <= SIPP_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = sda_oe_reg;

  // supply low sets the flag, and the set wins over a clear.
  // stop after a read clears it.
  always_ff @(posedge clk) begin
    if (reset) begin
      por_reg <= 1'b1;
    end else if (low_s) begin
      por_reg <= 1'b1;
    end else if (bus_stop && rw_reg) begin
      por_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  sipp_next_t  next_reg;
  logic [7:0]  upper_reg;
  logic [7:0]  ctl_reg;
  logic [7:0]  prt_reg;
  logic [14:0] ratio_reg;

  // Lost supply drops the programmed settings just as a reset does.
  // bytes land only on their eighth bit, so a broken byte changes nothing.
  always_ff @(posedge clk) begin
    if (reset || low_s) begin
      next_reg  <= SIPP_NEXT_SEL;
      upper_reg <= SIPP_UPPER_RESET;
      ctl_reg   <= SIPP_CTL_RESET;
      prt_reg   <= SIPP_PRT_RESET;
      ratio_reg <= SIPP_RATIO_RESET;
    end else if (addr_hit) begin
      next_reg <= SIPP_NEXT_SEL;
    end else if (wr_commit) begin
      case (next_reg)
        // leading bit selects divider or control byte.
        SIPP_NEXT_SEL: begin
          if (shift_reg[SIPP_CTL_LEAD]) begin
            ctl_reg  <= shift_reg;
            next_reg <= SIPP_NEXT_PORTS;
          end else begin
            upper_reg <= shift_reg;
            next_reg  <= SIPP_NEXT_LOWER;
          end
        end
        // fifteen bit ratio assembled on the lower byte.
        SIPP_NEXT_LOWER: begin
          ratio_reg <= {upper_reg[6:0], shift_reg};
          next_reg  <= SIPP_NEXT_SEL;
        end
        SIPP_NEXT_PORTS: begin
          prt_reg  <= shift_reg;
          next_reg <= SIPP_NEXT_SEL;
        end
        default: begin
          next_reg <= SIPP_NEXT_SEL;
        end
      endcase
    end
  end

  // drive off depends on its own bit only.
  assign divider_ratio      = ratio_reg;
  assign pump_current_sel   = ctl_reg[SIPP_CTL_PUMP];
  assign test_mode_sel      = ctl_reg[SIPP_CTL_TEST];
  assign pump_off           = ctl_reg[SIPP_CTL_OFF];
  assign varactor_drive_off = ctl_reg[SIPP_CTL_DRIVE];

  // one bit per port; a one turns the port on (pulls low).
  // ports reset to zero, which is off.
  assign io_port_7_oe = prt_reg[SIPP_PRT_7];
  assign io_port_6_oe = prt_reg[SIPP_PRT_6];
  assign io_port_5_oe = prt_reg[SIPP_PRT_5];
  assign io_port_4_oe = prt_reg[SIPP_PRT_4];
  assign out_port_3   = prt_reg[SIPP_PRT_3];
  assign out_port_0   = prt_reg[SIPP_PRT_0];
  assign io_port_o    = 1'b0;

  ////////////////////////////////////////////////////////////////////////////

  a_por_set:
    assert property (@(posedge clk) disable iff (reset) low_s |=> por_reg)
    else $error("power-on flag not set by low supply");

  a_por_clear:
    assert property (@(posedge clk) disable iff (reset) bus_stop && rw_reg && !low_s |=> !por_reg)
    else $error("power-on flag not cleared by stop after read");

  a_ports_off:
    assert property (@(posedge clk) disable iff (reset)
      low_s |=> !io_port_4_oe && !io_port_5_oe && !io_port_6_oe && !io_port_7_oe && !out_port_0 && !out_port_3)
    else $error("ports not off after settings lost");

  a_status_load:
    assert property (@(posedge clk) disable iff (reset)
      state_reg == SIPP_ACK && scl_fall && rw_reg && !bus_start && !bus_stop
      |=> state_reg == SIPP_RD && shift_reg[6:3] == $past({lock_s, port7_level, port5_level, port4_level}))
    else $error("status byte fields wrong at load");

  a_msb_first:
    assert property (@(posedge clk) disable iff (reset)
      state_reg == SIPP_RD |-> sda_oe_reg == !shift_reg[7])
    else $error("first status bit not on the data line");

  a_ack_addr:
    assert property (@(posedge clk) disable iff (reset) addr_hit && !bus_start && !bus_stop
      |=> sda_oe_reg && state_reg == SIPP_ACK)
    else $error("matching address not acknowledged");

  a_reject_addr:
    assert property (@(posedge clk) disable iff (reset)
      state_reg == SIPP_ADDR && byte_done && !addr_hit && !bus_start && !bus_stop
      |=> !sda_oe_reg && state_reg == SIPP_WAIT)
    else $error("foreign address acknowledged");

  a_upper_pick:
    assert property (@(posedge clk) disable iff (reset)
      wr_commit && next_reg == SIPP_NEXT_SEL && !shift_reg[7] && !low_s |=> next_reg == SIPP_NEXT_LOWER)
    else $error("leading zero byte not taken as upper divider");

  a_ratio_build:
    assert property (@(posedge clk) disable iff (reset)
      wr_commit && next_reg == SIPP_NEXT_LOWER && !low_s
      |=> divider_ratio == {$past(upper_reg[6:0]), $past(shift_reg)})
    else $error("division ratio assembled wrongly");

  a_drive_off:
    assert property (@(posedge clk) disable iff (reset)
      wr_commit && next_reg == SIPP_NEXT_SEL && shift_reg[7] && !low_s
      |=> varactor_drive_off == $past(shift_reg[0]) && pump_off == $past(shift_reg[4]))
    else $error("control byte bits not applied");

  a_abort_keep:
    assert property (@(posedge clk) disable iff (reset)
      bus_stop && state_reg == SIPP_WR && cnt_reg != SIPP_BITS_PER_BYTE && !low_s
      |=> $stable(divider_ratio) && $stable(ctl_reg) && $stable(prt_reg))
    else $error("broken byte changed a setting");

endmodule : sipp_top

// *** test/sipp_master.sv ***
// Bus master model that drives the serial clock and pulls the data line of the programming port.
module sipp_master (
  // Clock
  input  wire logic       clk,
  // Bus lines
  input  wire logic       sda_line,
  output logic            scl,
  output logic            sda_pull,
  // Result of the last byte
  output logic            done,
  output logic            ack_seen,
  output logic [7:0]      rd_byte
);
  timeunit 1ns;
  timeprecision 100ps;

  // Phases sit well above the five clock minimum so the pin synchronisers never blur an edge.
  localparam int HALF = 8;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    done = 1'b0;
    ack_seen = 1'b1;
    rd_byte = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  task automatic bus_start();
    sda_pull = 1'b0;
    scl = 1'b1;
    wait_clk(HALF);
    sda_pull = 1'b1;
    wait_clk(HALF);
    scl = 1'b0;
    wait_clk(2);
  endtask : bus_start

  task automatic bus_stop();
    sda_pull = 1'b1;
    wait_clk(HALF);
    scl = 1'b1;
    wait_clk(HALF);
    sda_pull = 1'b0;
    wait_clk(HALF);
  endtask : bus_stop

  // Data is changed two clocks after the clock falls, so it is never seen moving with the clock.
  task automatic put_bit(input logic b, output logic s);
    sda_pull = ~b;
    wait_clk(HALF);
    scl = 1'b1;
    wait_clk(HALF);
    s = sda_line;
    scl = 1'b0;
    wait_clk(2);
  endtask : put_bit

  //////////////////////////////////////////////////////////////////////////////
  // most significant first
  task automatic xfer(input logic [7:0] wr, input logic ack_in);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(wr[i], s);
      rd_byte[i] = s;
    end
    put_bit(ack_in, s);
    ack_seen = s;
    done = 1'b1;
    wait_clk(1);
    done = 1'b0;
  endtask : xfer
endmodule : sipp_master

// *** test/sipp_top_tb_top.sv ***
// Self-checking bench for the synthesiser programming port.
module sipp_top_tb_top
  import sipp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [2:0]  kind;
    logic [14:0] val;
  } sipp_note_t;

  localparam logic [7:0] WR_ADDR = {SIPP_ADDR_FIXED, SIPP_SEL_ALWAYS, 1'b0};
  localparam logic [7:0] RD_ADDR = {SIPP_ADDR_FIXED, SIPP_SEL_ALWAYS, 1'b1};

  logic        clk, reset, supply_low, lock_flag, ext4, ext5, ext7, bit_seen, hit;
  logic        sda_o, sda_oe, scl, m_pull, m_done, m_ack, io_port_o;
  logic        out_port_0, out_port_3, io_port_4_oe, io_port_5_oe, io_port_6_oe, io_port_7_oe;
  logic        pump_current_sel, test_mode_sel, pump_off, varactor_drive_off;
  logic [3:0]  conv_cmp, sel_cmp;
  logic [7:0]  m_byte, ctl, prt;
  logic [14:0] divider_ratio, ratio;
  int          err_count, comparisons;
  sipp_note_t  notes[$];
  sipp_note_t  cur;
  wire logic   sda_line = ~((sda_oe & ~sda_o) | m_pull);
  wire logic   pin4 = io_port_4_oe ? io_port_o : ext4;
  wire logic   pin5 = io_port_5_oe ? io_port_o : ext5;
  wire logic   pin7 = io_port_7_oe ? io_port_o : ext7;

  always #12.5 clk = ~clk;

  sipp_top u_sipp_top (.clk(clk), .reset(reset), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .supply_low(supply_low), .lock_flag(lock_flag), .conv_cmp(conv_cmp), .sel_cmp(sel_cmp),
    .io_port_4_i(pin4), .io_port_5_i(pin5), .io_port_7_i(pin7), .out_port_0(out_port_0),
    .out_port_3(out_port_3), .io_port_4_oe(io_port_4_oe), .io_port_5_oe(io_port_5_oe),
    .io_port_6_oe(io_port_6_oe), .io_port_7_oe(io_port_7_oe), .io_port_o(io_port_o),
    .divider_ratio(divider_ratio), .pump_current_sel(pump_current_sel), .test_mode_sel(test_mode_sel),
    .pump_off(pump_off), .varactor_drive_off(varactor_drive_off));

  sipp_master u_sipp_master (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(m_pull), .done(m_done),
    .ack_seen(m_ack), .rd_byte(m_byte));

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [14:0] obs(input logic [2:0] k);
    case (k)
      3'h0: return {14'h0000, m_ack};
      3'h1: return {7'h00, m_byte};
      3'h2: return divider_ratio;
      3'h3: return {11'h000, pump_current_sel, test_mode_sel, pump_off, varactor_drive_off};
      default: return {9'h000, io_port_7_oe, io_port_6_oe, io_port_5_oe, io_port_4_oe, out_port_3, out_port_0};
    endcase
  endfunction : obs

  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic note(input logic [2:0] k, input logic [14:0] v);
    notes.push_back({k, v});
  endtask : note

  task automatic wr(input logic [7:0] b);
    note(3'h0, 15'h0000);
    u_sipp_master.xfer(b, 1'b1);
  endtask : wr

  task automatic tally_and_finish();
    if (notes.size() != 0) err_count++;
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Every note left before a byte ends is judged once that byte's acknowledge bit has been clocked, acknowledged or not.
  always @(posedge clk) begin
    if (m_done === 1'b1) begin
      while (notes.size() > 0) begin
        cur = notes.pop_front();
        check(obs(cur.kind), cur.val);
      end
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    {reset, supply_low, lock_flag, ext4, ext5, ext7} = 6'h20;
    {conv_cmp, sel_cmp} = 8'h00;
    err_count = 0;
    comparisons = 0;
    void'($urandom(32'h507176C5));
    repeat (12) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    check(obs(3'h4), 15'h0000);
    check(obs(3'h3), {11'h000, SIPP_CTL_RESET[6:4], SIPP_CTL_RESET[0]});
    for (int n = 0; n <= 4; n++) begin
      {lock_flag, ext4, ext5, ext7} = 4'($urandom);
      conv_cmp = 4'((1 << n) - 1);
      u_sipp_master.bus_start();
      wr(RD_ADDR);
      note(3'h1, {7'h00, n == 0, lock_flag, ext7, ext5, ext4, 3'(n)});
      u_sipp_master.xfer(8'hFF, 1'b0);
      note(3'h1, {7'h00, n == 0, lock_flag, ext7, ext5, ext4, 3'(n)});
      u_sipp_master.xfer(8'hFF, 1'b1);
      u_sipp_master.bus_stop();
    end
    for (int c = 0; c <= 4; c++) begin
      sel_cmp = 4'((1 << c) - 1);
      for (int s = 0; s < 4; s++) begin
        hit = (s == 1) || (c == 0 && s == 0) || (c == 2 && s == 2) || (c == 4 && s == 3);
        u_sipp_master.bus_start();
        note(3'h0, {14'h0000, ~hit});
        u_sipp_master.xfer({SIPP_ADDR_FIXED, 2'(s), 1'b0}, 1'b1);
        u_sipp_master.bus_stop();
      end
    end
    for (int i = 0; i < 3; i++) begin
      ratio = 15'($urandom);
      ctl = {1'b1, 3'($urandom), 3'h7, 1'($urandom)};
      prt = 8'($urandom);
      u_sipp_master.bus_start();
      wr(WR_ADDR);
      wr({1'b0, ratio[14:8]});
      note(3'h2, ratio);
      wr(ratio[7:0]);
      note(3'h3, {11'h000, ctl[6:4], ctl[0]});
      wr(ctl);
      note(3'h4, {9'h000, prt[7:3], prt[0]});
      wr(prt);
      u_sipp_master.bus_stop();
    end
    // bytes broken off keep old values
    u_sipp_master.bus_start();
    wr(WR_ADDR);
    wr(8'h05);
    for (int b = 0; b < 4; b++) u_sipp_master.put_bit(1'b1, bit_seen);
    u_sipp_master.bus_stop();
    u_sipp_master.bus_start();
    wr(WR_ADDR);
    for (int b = 0; b < 5; b++) u_sipp_master.put_bit(b[0] == 1'b0, bit_seen);
    u_sipp_master.bus_stop();
    u_sipp_master.bus_start();
    note(3'h2, ratio);
    note(3'h3, {11'h000, ctl[6:4], ctl[0]});
    note(3'h4, {9'h000, prt[7:3], prt[0]});
    wr(WR_ADDR);
    u_sipp_master.bus_stop();
    // ports switched on read back low
    {ext4, ext5, ext7} = 3'h7;
    u_sipp_master.bus_start();
    wr(RD_ADDR);
    note(3'h1, {7'h00, 1'b0, lock_flag, ~prt[7], ~prt[5], ~prt[4], SIPP_CONV_B4});
    u_sipp_master.xfer(8'hFF, 1'b1);
    u_sipp_master.bus_stop();
    // low supply loses settings, ports read as inputs
    supply_low = 1'b1;
    repeat (8) @(negedge clk);
    supply_low = 1'b0;
    repeat (4) @(negedge clk);
    u_sipp_master.bus_start();
    note(3'h2, SIPP_RATIO_RESET);
    note(3'h4, 15'h0000);
    wr(RD_ADDR);
    note(3'h1, {7'h00, 1'b1, lock_flag, ext7, ext5, ext4, SIPP_CONV_B4});
    u_sipp_master.xfer(8'hFF, 1'b1);
    u_sipp_master.bus_stop();
    tally_and_finish();
  end
endmodule : sipp_top_tb_top
